// *** timer2_mode_pkg.sv ***
// Constants and types shared by the mode-engine timer and its bench.
`default_nettype none
package timer2_mode_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  // Register byte offsets.
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_MODE        = 8'h04;
  localparam logic [7:0]  OFS_RCAP_LO     = 8'h08;
  localparam logic [7:0]  OFS_RCAP_HI     = 8'h0c;
  localparam logic [7:0]  OFS_COUNT_LO    = 8'h10;
  localparam logic [7:0]  OFS_COUNT_HI    = 8'h14;
  localparam logic [7:0]  OFS_FREQ        = 8'h18;
  localparam logic [7:0]  OFS_IRQ_EN      = 8'h1c;
  // Control register fields.
  localparam int          B_OVF_FLAG      = 7;
  localparam int          B_EXT_FLAG      = 6;
  localparam int          B_RX_BAUD       = 5;
  localparam int          B_TX_BAUD       = 4;
  localparam int          B_EXT_TRIG_EN   = 3;
  localparam int          B_RUN           = 2;
  localparam int          B_COUNT_SRC     = 1;
  localparam int          B_CAP_RELOAD    = 0;
  // Mode register fields.
  localparam int          B_CLK_OUT_EN    = 1;
  localparam int          B_DOWN_EN       = 0;
  // Frequency register field.
  localparam int          B_PRESCALE_BYP  = 0;
  // Interrupt enable register fields.
  localparam int          B_GLOBAL_IRQ    = 1;
  localparam int          B_TIMER_IRQ     = 0;
  // Reset values.
  localparam logic [7:0]  CTRL_RST        = 8'h00;
  localparam logic [1:0]  MODE_RST        = 2'h0;
  localparam logic [15:0] WORD_RST        = 16'h0000;
  // Counter constants.
  localparam logic [15:0] FULL_SCALE      = 16'hffff;
  localparam logic [15:0] COUNT_STEP      = 16'h0001;
  localparam int          PRESCALE_DIV    = 12;
  localparam logic [3:0]  PRESCALE_LAST   = 4'(PRESCALE_DIV - 1);
  localparam logic [3:0]  PRESCALE_STEP   = 4'h1;
  localparam logic [3:0]  PRESCALE_RST    = 4'h0;

  typedef enum logic [1:0] {
    MODE_CAPTURE = 2'b00,
    MODE_RELOAD  = 2'b01,
    MODE_BAUD    = 2'b11,
    MODE_CLKOUT  = 2'b10
  } op_mode_type;
endpackage : timer2_mode_pkg
`default_nettype wire

// *** timer2_mode_engine.sv ***
// Sixteen-bit timer with capture, reload, baud and clock-output modes.
`default_nettype none

module timer2_mode_engine
  import timer2_mode_pkg::*;
(
  input  wire logic                                 I_CORE_CLK,
  input  wire logic                                 I_RST_N,
  input  wire logic                                 I_PSEL,
  input  wire logic                                 I_PENABLE,
  input  wire logic                                 I_PWRITE,
  input  wire logic [timer2_mode_pkg::ADDR_W-1:0]   I_PADDR,
  input  wire logic [timer2_mode_pkg::DATA_W-1:0]   I_PWDATA,
  output logic      [timer2_mode_pkg::DATA_W-1:0]   O_PRDATA,
  output logic                                      O_PREADY,
  output logic                                      O_PSLVERR,
  input  wire logic                                 I_EXT_TRIGGER_PIN,
  input  wire logic                                 I_COUNT_CLK_PIN,
  output logic                                      O_COUNT_CLK_PIN,
  output logic                                      O_COUNT_CLK_PIN_OE,
  output logic                                      O_TIMER_IRQ,
  output logic                                      O_RX_BAUD_SEL,
  output logic                                      O_TX_BAUD_SEL,
  output logic                                      O_RX_BAUD_TICK,
  output logic                                      O_TX_BAUD_TICK
);
  import timer2_mode_pkg::*;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a == OFS_CTRL) || (a == OFS_MODE) || (a == OFS_RCAP_LO) ||
              (a == OFS_RCAP_HI) || (a == OFS_COUNT_LO) ||
              (a == OFS_COUNT_HI) || (a == OFS_FREQ) || (a == OFS_IRQ_EN);
  endfunction

  logic [7:0]  ctrl_reg, ctrl_next;
  logic [1:0]  mode_reg, irqen_reg;
  logic [15:0] rcap_reg, rcap_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [3:0]  div_reg;
  logic        bypass_reg, half_reg, pready_reg, access;
  logic        trig_s1_reg, trig_s2_reg, trig_s3_reg;
  logic        cpin_s1_reg, cpin_s2_reg, cpin_s3_reg;
  logic        wr_ctrl, wr_mode, wr_rcap_lo, wr_rcap_hi;
  logic        wr_cnt_lo, wr_cnt_hi, wr_freq, wr_irqen;
  logic        div_tick, tmr_tick, trig_fall, cpin_fall, src_tick;
  logic        cnt_en, run, ext_en, updown;
  logic        tf_set, exf_set, exf_tgl, ovf;
  op_mode_type op_mode;

  // APB access phase completes one cycle after it opens.
  assign access    = I_PSEL & I_PENABLE & pready_reg;
  assign wr_ctrl   = access & I_PWRITE & (I_PADDR == OFS_CTRL);
  assign wr_mode   = access & I_PWRITE & (I_PADDR == OFS_MODE);
  assign wr_rcap_lo = access & I_PWRITE & (I_PADDR == OFS_RCAP_LO);
  assign wr_rcap_hi = access & I_PWRITE & (I_PADDR == OFS_RCAP_HI);
  assign wr_cnt_lo = access & I_PWRITE & (I_PADDR == OFS_COUNT_LO);
  assign wr_cnt_hi = access & I_PWRITE & (I_PADDR == OFS_COUNT_HI);
  assign wr_freq   = access & I_PWRITE & (I_PADDR == OFS_FREQ);
  assign wr_irqen  = access & I_PWRITE & (I_PADDR == OFS_IRQ_EN);

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= I_PSEL & I_PENABLE & ~pready_reg;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PRDATA  <= '0;
      O_PSLVERR <= 1'b0;
    end else if (I_PSEL & I_PENABLE & ~pready_reg) begin
      O_PSLVERR <= ~reg_hit(I_PADDR);
      O_PRDATA  <= '0;
      unique case (I_PADDR)
        OFS_CTRL:     O_PRDATA[7:0] <= ctrl_reg;
        OFS_MODE:     O_PRDATA[1:0] <= mode_reg;
        OFS_RCAP_LO:  O_PRDATA[7:0] <= rcap_reg[7:0];
        OFS_RCAP_HI:  O_PRDATA[7:0] <= rcap_reg[15:8];
        OFS_COUNT_LO: O_PRDATA[7:0] <= cnt_reg[7:0];
        OFS_COUNT_HI: O_PRDATA[7:0] <= cnt_reg[15:8];
        OFS_FREQ:     O_PRDATA[B_PRESCALE_BYP] <= bypass_reg;
        OFS_IRQ_EN:   O_PRDATA[1:0] <= irqen_reg;
        default:      O_PRDATA <= '0;
      endcase
    end else begin
      O_PSLVERR <= 1'b0;
    end
  end
  assign O_PREADY = pready_reg;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mode_reg   <= MODE_RST;
      bypass_reg <= 1'b0;
      irqen_reg  <= MODE_RST;
    end else begin
      if (wr_mode) begin
        mode_reg <= I_PWDATA[1:0];
      end
      if (wr_freq) begin
        bypass_reg <= I_PWDATA[B_PRESCALE_BYP];
      end
      if (wr_irqen) begin
        irqen_reg <= I_PWDATA[1:0];
      end
    end
  end

  // Pins pass two flip-flops; the third stage only serves edge detection.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      trig_s1_reg <= 1'b1;
      trig_s2_reg <= 1'b1;
      trig_s3_reg <= 1'b1;
      cpin_s1_reg <= 1'b1;
      cpin_s2_reg <= 1'b1;
      cpin_s3_reg <= 1'b1;
    end else begin
      trig_s1_reg <= I_EXT_TRIGGER_PIN;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
      cpin_s1_reg <= I_COUNT_CLK_PIN;
      cpin_s2_reg <= cpin_s1_reg;
      cpin_s3_reg <= cpin_s2_reg;
    end
  end
  assign trig_fall = trig_s3_reg & ~trig_s2_reg;
  assign cpin_fall = cpin_s3_reg & ~cpin_s2_reg;

  // Divide-by-twelve prescaler.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      div_reg <= PRESCALE_RST;
    end else if (div_tick) begin
      div_reg <= PRESCALE_RST;
    end else begin
      div_reg <= div_reg + PRESCALE_STEP;
    end
  end
  assign div_tick = (div_reg == PRESCALE_LAST);
  assign tmr_tick = bypass_reg | div_tick;

  // Clock output mode advances the counter on every second timer tick.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      half_reg <= 1'b0;
    end else if (op_mode == MODE_CLKOUT && run && tmr_tick) begin
      half_reg <= ~half_reg;
    end
  end

  assign run    = ctrl_reg[B_RUN];
  assign ext_en = ctrl_reg[B_EXT_TRIG_EN];
  always_comb begin
    if (mode_reg[B_CLK_OUT_EN] && !ctrl_reg[B_COUNT_SRC]) begin
      op_mode = MODE_CLKOUT;
    end else if (ctrl_reg[B_RX_BAUD] || ctrl_reg[B_TX_BAUD]) begin
      op_mode = MODE_BAUD;
    end else if (ctrl_reg[B_CAP_RELOAD]) begin
      op_mode = MODE_CAPTURE;
    end else begin
      op_mode = MODE_RELOAD;
    end
  end

  assign updown   = (op_mode == MODE_RELOAD) && mode_reg[B_DOWN_EN];
  assign src_tick = ctrl_reg[B_COUNT_SRC] ? cpin_fall : tmr_tick;
  always_comb begin
    unique case (op_mode)
      MODE_BAUD:   cnt_en = run;
      MODE_CLKOUT: cnt_en = run & tmr_tick & half_reg;
      default:     cnt_en = run & src_tick;
    endcase
  end

  always_comb begin
    cnt_next  = cnt_reg;
    rcap_next = rcap_reg;
    tf_set    = 1'b0;
    exf_set   = ext_en & trig_fall & ~updown;
    exf_tgl   = 1'b0;
    ovf       = 1'b0;
    unique case (op_mode)
      MODE_CAPTURE: begin
        if (cnt_en) begin
          cnt_next = cnt_reg + COUNT_STEP;
          tf_set   = (cnt_reg == FULL_SCALE);
        end
        if (run && ext_en && trig_fall) begin
          rcap_next = cnt_reg;
        end
      end
      MODE_RELOAD: begin
        if (updown) begin
          if (cnt_en && trig_s2_reg) begin
            if (cnt_reg == FULL_SCALE) begin
              cnt_next = rcap_reg;
              tf_set   = 1'b1;
              exf_tgl  = 1'b1;
            end else begin
              cnt_next = cnt_reg + COUNT_STEP;
            end
          end else if (cnt_en) begin
            if (cnt_reg == rcap_reg) begin
              cnt_next = FULL_SCALE;
              tf_set   = 1'b1;
              exf_tgl  = 1'b1;
            end else begin
              cnt_next = cnt_reg - COUNT_STEP;
            end
          end
        end else begin
          if (cnt_en) begin
            if (cnt_reg == FULL_SCALE) begin
              cnt_next = rcap_reg;
              tf_set   = 1'b1;
            end else begin
              cnt_next = cnt_reg + COUNT_STEP;
            end
          end
          if (run && ext_en && trig_fall) begin
            cnt_next = rcap_reg;
          end
        end
      end
      MODE_BAUD, MODE_CLKOUT: begin
        if (cnt_en) begin
          if (cnt_reg == FULL_SCALE) begin
            cnt_next = rcap_reg;
            ovf      = 1'b1;
          end else begin
            cnt_next = cnt_reg + COUNT_STEP;
          end
        end
      end
    endcase
  end

  // A hardware set wins over a software clear in the same cycle.
  always_comb begin
    ctrl_next = wr_ctrl ? I_PWDATA[7:0] : ctrl_reg;
    if (tf_set) begin
      ctrl_next[B_OVF_FLAG] = 1'b1;
    end
    if (exf_tgl) begin
      ctrl_next[B_EXT_FLAG] = ~ctrl_next[B_EXT_FLAG];
    end else if (exf_set) begin
      ctrl_next[B_EXT_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_reg <= CTRL_RST;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Software writes to the count and reload bytes win over the engine.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cnt_reg  <= WORD_RST;
      rcap_reg <= WORD_RST;
    end else begin
      cnt_reg  <= cnt_next;
      rcap_reg <= rcap_next;
      if (wr_cnt_lo) begin
        cnt_reg[7:0] <= I_PWDATA[7:0];
      end
      if (wr_cnt_hi) begin
        cnt_reg[15:8] <= I_PWDATA[7:0];
      end
      if (wr_rcap_lo) begin
        rcap_reg[7:0] <= I_PWDATA[7:0];
      end
      if (wr_rcap_hi) begin
        rcap_reg[15:8] <= I_PWDATA[7:0];
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_TIMER_IRQ <= 1'b0;
    end else begin
      O_TIMER_IRQ <= irqen_reg[B_GLOBAL_IRQ] & irqen_reg[B_TIMER_IRQ] &
                     (ctrl_reg[B_OVF_FLAG] |
                      (ctrl_reg[B_EXT_FLAG] & ~updown));
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_COUNT_CLK_PIN    <= 1'b0;
      O_COUNT_CLK_PIN_OE <= 1'b0;
      O_RX_BAUD_SEL      <= 1'b0;
      O_TX_BAUD_SEL      <= 1'b0;
      O_RX_BAUD_TICK     <= 1'b0;
      O_TX_BAUD_TICK     <= 1'b0;
    end else begin
      O_COUNT_CLK_PIN_OE <= (op_mode == MODE_CLKOUT);
      if (op_mode != MODE_CLKOUT) begin
        O_COUNT_CLK_PIN <= 1'b0;
      end else if (ovf) begin
        O_COUNT_CLK_PIN <= ~O_COUNT_CLK_PIN;
      end
      O_RX_BAUD_SEL  <= ctrl_next[B_RX_BAUD];
      O_TX_BAUD_SEL  <= ctrl_next[B_TX_BAUD];
      O_RX_BAUD_TICK <= ovf & ctrl_reg[B_RX_BAUD];
      O_TX_BAUD_TICK <= ovf & ctrl_reg[B_TX_BAUD];
    end
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  property p_capture;
    (op_mode == MODE_CAPTURE && run && ext_en && trig_fall &&
     !wr_rcap_lo && !wr_rcap_hi)
      |=> (rcap_reg == $past(cnt_reg)) && ctrl_reg[B_EXT_FLAG];
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not copy count or set event flag");
  property p_flag_hold;
    (ctrl_reg[B_OVF_FLAG] && !wr_ctrl) |=> ctrl_reg[B_OVF_FLAG];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("overflow flag cleared without software write");
  property p_irq;
    ##1 O_TIMER_IRQ == $past(irqen_reg[B_GLOBAL_IRQ] &
      irqen_reg[B_TIMER_IRQ] & (ctrl_reg[B_OVF_FLAG] |
      (ctrl_reg[B_EXT_FLAG] & ~updown)));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request disagrees with flags and enables");
  property p_down_match;
    (updown && cnt_en && !trig_s2_reg && cnt_reg == rcap_reg &&
     !wr_cnt_lo && !wr_cnt_hi && !wr_ctrl)
      |=> cnt_reg == FULL_SCALE && ctrl_reg[B_OVF_FLAG];
  endproperty
  a_down_match: assert property (p_down_match)
    else $error("down count match did not load all ones");
  property p_up_reload;
    (op_mode == MODE_RELOAD && cnt_en && cnt_reg == FULL_SCALE &&
     (!updown || trig_s2_reg) && !wr_cnt_lo && !wr_cnt_hi && !wr_ctrl)
      |=> cnt_reg == $past(rcap_reg) && ctrl_reg[B_OVF_FLAG];
  endproperty
  a_up_reload: assert property (p_up_reload)
    else $error("overflow did not reload counter and set flag");
  property p_baud_noflag;
    (op_mode == MODE_BAUD && !wr_ctrl)
      |=> ctrl_reg[B_OVF_FLAG] == $past(ctrl_reg[B_OVF_FLAG]);
  endproperty
  a_baud_noflag: assert property (p_baud_noflag)
    else $error("baud mode changed the overflow flag");
  property p_stop;
    (!run && !wr_cnt_lo && !wr_cnt_hi && !wr_ctrl &&
     !(op_mode == MODE_RELOAD && ext_en && trig_fall)) |=> $stable(cnt_reg);
  endproperty
  a_stop: assert property (p_stop)
    else $error("counter moved while stopped");
  property p_prescale;
    (!bypass_reg && div_tick) |=> !div_tick [*8];
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("prescaler ticked too soon");
  property p_clkout_oe;
    (op_mode == MODE_CLKOUT) |=> O_COUNT_CLK_PIN_OE;
  endproperty
  a_clkout_oe: assert property (p_clkout_oe)
    else $error("count pin not driven in clock output mode");

endmodule // timer2_mode_engine
`default_nettype wire

// *** timer2_pins_model.sv ***
// Model of the trigger and count pins and of the baud tick consumer.
`default_nettype none
module timer2_pins_model (
  input  wire logic i_clk,
  input  wire logic i_count_pin,
  input  wire logic i_rx_tick,
  input  wire logic i_tx_tick,
  output logic      o_trigger,
  output logic      o_count_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  int   rx_ticks;
  int   tx_ticks;
  int   clk_rises;
  logic last_pin;

  // Both pins idle high, as a pulled-up line would.
  initial begin
    o_trigger   = 1'b1;
    o_count_drv = 1'b1;
    rx_ticks    = 0;
    tx_ticks    = 0;
    clk_rises   = 0;
    last_pin    = 1'b1;
  end

  always @(posedge i_clk) begin
    rx_ticks  <= rx_ticks + int'(i_rx_tick);
    tx_ticks  <= tx_ticks + int'(i_tx_tick);
    last_pin  <= i_count_pin;
    if (i_count_pin && !last_pin) begin
      clk_rises <= clk_rises + 1;
    end
  end

  // Each level is held six clocks so the synchroniser sees every edge.
  task automatic hold(input logic lvl, input bit trig);
    if (trig) begin
      o_trigger <= lvl;
    end else begin
      o_count_drv <= lvl;
    end
    repeat (6) @(posedge i_clk);
  endtask
endmodule // timer2_pins_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the mode-engine timer.
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  failures++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import timer2_mode_pkg::*;
  localparam logic [7:0] SRC = 8'h1 << B_COUNT_SRC;
  localparam logic [7:0] RUN = 8'h1 << B_RUN;
  localparam logic [7:0] TEN = 8'h1 << B_EXT_TRIG_EN;
  localparam logic [7:0] CAP = 8'h1 << B_CAP_RELOAD;
  localparam logic [7:0] RXB = 8'h1 << B_RX_BAUD;
  localparam logic [7:0] TXB = 8'h1 << B_TX_BAUD;
  localparam logic [7:0] OVF = 8'h1 << B_OVF_FLAG;
  localparam logic [7:0] EXT = 8'h1 << B_EXT_FLAG;
  typedef struct {
    logic [7:0] a;
    logic [7:0] wd;
    logic [7:0] exp;
    logic       err;
  } row_type;
  logic              clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rdata;
  logic              rerr, trig, cnt_drv, cnt_o, cnt_oe, irq;
  logic              rx_sel, tx_sel, rx_tk, tx_tk;
  logic [15:0]       v16;
  wire logic         cnt_pin;
  int                failures, samples_checked, cycles, d0, d1;
  row_type           rows [9];

  assign cnt_pin = cnt_oe ? cnt_o : cnt_drv;

  timer2_mode_engine uut (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_EXT_TRIGGER_PIN(trig),
    .I_COUNT_CLK_PIN(cnt_pin), .O_COUNT_CLK_PIN(cnt_o),
    .O_COUNT_CLK_PIN_OE(cnt_oe), .O_TIMER_IRQ(irq),
    .O_RX_BAUD_SEL(rx_sel), .O_TX_BAUD_SEL(tx_sel),
    .O_RX_BAUD_TICK(rx_tk), .O_TX_BAUD_TICK(tx_tk));

  timer2_pins_model pins (
    .i_clk(clk), .i_count_pin(cnt_pin), .i_rx_tick(rx_tk),
    .i_tx_tick(tx_tk), .o_trigger(trig), .o_count_drv(cnt_drv));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask

  task automatic w16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h04, v[15:8]);
  endtask

  task automatic r16(input logic [7:0] a);
    rd(a);
    v16[7:0] = rdata[7:0];
    rd(a + 8'h04);
    v16[15:8] = rdata[7:0];
  endtask

  task automatic pulse(input int n);
    repeat (n) begin
      pins.hold(1'b0, 1'b0);
      pins.hold(1'b1, 1'b0);
    end
  endtask

  task automatic trig_fall();
    pins.hold(1'b0, 1'b1);
    pins.hold(1'b1, 1'b1);
  endtask

  initial begin
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    rows = '{'{OFS_MODE, 8'hff, 8'h03, 1'b0},
             '{OFS_RCAP_LO, 8'h5a, 8'h5a, 1'b0},
             '{OFS_RCAP_HI, 8'ha5, 8'ha5, 1'b0},
             '{OFS_COUNT_LO, 8'h3c, 8'h3c, 1'b0},
             '{OFS_COUNT_HI, 8'hc3, 8'hc3, 1'b0},
             '{OFS_FREQ, 8'hff, 8'h01, 1'b0},
             '{OFS_IRQ_EN, 8'hff, 8'h03, 1'b0},
             '{8'h20, 8'h77, 8'h00, 1'b1},
             '{OFS_CTRL, 8'h00, 8'h00, 1'b0}};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].wd);
      rd(rows[i].a);
      `CHK("read data", {24'h0, rows[i].exp}, rdata)
      `CHK("slave error", rows[i].err, rerr)
    end
    $display("test register table done");

    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 32; a += 4) begin
      rd(8'(a));
      `CHK("reset value", 32'h0, rdata)
    end
    $display("test reset done");

    w16(OFS_COUNT_LO, 16'h1234);
    wr(OFS_IRQ_EN, 8'h03);
    wr(OFS_CTRL, RUN | SRC | CAP | TEN);
    trig_fall();
    r16(OFS_RCAP_LO);
    `CHK("capture", 16'h1234, v16)
    rd(OFS_CTRL);
    `CHK("ctrl", RUN | SRC | CAP | TEN | EXT, rdata[7:0])
    `CHK("irq", 1'b1, irq)
    pulse(3);
    r16(OFS_COUNT_LO);
    `CHK("pin count", 16'h1237, v16)
    wr(OFS_CTRL, SRC | CAP | TEN);
    repeat (2) @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
    trig_fall();
    pulse(1);
    rd(OFS_CTRL);
    `CHK("stopped flag", SRC | CAP | TEN | EXT, rdata[7:0])
    r16(OFS_COUNT_LO);
    `CHK("stopped count", 16'h1237, v16)
    $display("test capture done");

    wr(OFS_CTRL, RUN | SRC | CAP);
    w16(OFS_COUNT_LO, 16'hffff);
    pulse(1);
    r16(OFS_COUNT_LO);
    `CHK("wrap", 16'h0000, v16)
    rd(OFS_CTRL);
    `CHK("ovf", RUN | SRC | CAP | OVF, rdata[7:0])
    wr(OFS_IRQ_EN, 8'h01);
    repeat (2) @(posedge clk);
    `CHK("irq masked", 1'b0, irq)
    wr(OFS_IRQ_EN, 8'h03);
    repeat (2) @(posedge clk);
    `CHK("irq on", 1'b1, irq)
    $display("test overflow done");

    wr(OFS_CTRL, RUN | SRC);
    w16(OFS_RCAP_LO, 16'hfff0);
    w16(OFS_COUNT_LO, 16'hfffe);
    pulse(2);
    r16(OFS_COUNT_LO);
    `CHK("reload", 16'hfff0, v16)
    wr(OFS_CTRL, RUN | SRC | TEN);
    pulse(3);
    trig_fall();
    r16(OFS_COUNT_LO);
    `CHK("edge reload", 16'hfff0, v16)
    rd(OFS_CTRL);
    `CHK("edge flag", RUN | SRC | TEN | EXT, rdata[7:0])
    $display("test reload done");

    wr(OFS_MODE, 8'h01);
    wr(OFS_CTRL, RUN | SRC | TEN);
    w16(OFS_RCAP_LO, 16'h0100);
    w16(OFS_COUNT_LO, 16'h0101);
    pins.hold(1'b0, 1'b1);
    r16(OFS_COUNT_LO);
    `CHK("no edge reload", 16'h0101, v16)
    pulse(2);
    r16(OFS_COUNT_LO);
    `CHK("down match", 16'hffff, v16)
    rd(OFS_CTRL);
    `CHK("down flags", RUN | SRC | TEN | OVF | EXT, rdata[7:0])
    pins.hold(1'b1, 1'b1);
    pulse(1);
    r16(OFS_COUNT_LO);
    `CHK("up reload", 16'h0100, v16)
    rd(OFS_CTRL);
    `CHK("bit17", RUN | SRC | TEN | OVF, rdata[7:0])
    wr(OFS_MODE, 8'h00);
    $display("test up down done");

    wr(OFS_CTRL, 8'h00);
    w16(OFS_RCAP_LO, 16'hfff0);
    w16(OFS_COUNT_LO, 16'hfff0);
    wr(OFS_CTRL, RUN | RXB | TEN);
    @(posedge clk);
    `CHK("rx sel", 2'b10, {rx_sel, tx_sel})
    d0 = pins.rx_ticks;
    d1 = pins.tx_ticks;
    repeat (160) @(posedge clk);
    d0 = pins.rx_ticks - d0;
    d1 = pins.tx_ticks - d1;
    `CHK("rx ticks", 1'b1, (d0 >= 9 && d0 <= 11))
    `CHK("tx ticks", 0, d1)
    trig_fall();
    rd(OFS_CTRL);
    `CHK("baud flags", RUN | RXB | TEN | EXT, rdata[7:0])
    wr(OFS_CTRL, RUN | TXB);
    @(posedge clk);
    `CHK("tx sel", 2'b01, {rx_sel, tx_sel})
    $display("test baud done");

    wr(OFS_CTRL, 8'h00);
    w16(OFS_RCAP_LO, 16'hfffe);
    wr(OFS_FREQ, 8'h01);
    wr(OFS_MODE, 8'h02);
    wr(OFS_CTRL, RUN);
    repeat (40) @(posedge clk);
    `CHK("clock oe", 1'b1, cnt_oe)
    d0 = pins.clk_rises;
    repeat (160) @(posedge clk);
    d0 = pins.clk_rises - d0;
    `CHK("fast rises", 1'b1, (d0 >= 19 && d0 <= 21))
    rd(OFS_CTRL);
    `CHK("no ovf", RUN, rdata[7:0])
    wr(OFS_FREQ, 8'h00);
    repeat (200) @(posedge clk);
    d0 = pins.clk_rises;
    repeat (960) @(posedge clk);
    d0 = pins.clk_rises - d0;
    `CHK("slow rises", 1'b1, (d0 >= 9 && d0 <= 11))
    $display("test clock out done");
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
